// ---- dv/csf_flag_bank_properties.sv ----
// Purpose: port checks for the special flag bank
// Assumes: one clock, reset rst active high
// Notes: bound from the bench top file
`timescale 1ns/1ps
module csf_flag_bank_props #(
  parameter int unsigned HALF_SEC_CYCLES = 5
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic funcSwitchRun,
  input wire logic stopInput,
  input wire logic resetInput,
  input wire logic cpuRun,
  input wire logic selfHoldClear,
  input wire logic [15:0] physOutputs,
  input wire logic linkInitPulse,
  input wire logic oneSecPulse,
  input wire logic cardInserted,
  input wire logic cardAccessEnable
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // ==========================================
  // helper: low run of the pulse, 32 bits never wraps in a run
  logic [31:0] loCnt;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) loCnt <= 32'h0;
    else if (oneSecPulse) loCnt <= 32'h0;
    else loCnt <= loCnt + 32'h1;
  end
  // ==========================================
  // properties
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  property p_rd_answer;
    s_rd_take |=> s_axi_rvalid;
  endproperty
  property p_rd_block;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  property p_wr_done;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  property p_override;
    stopInput || resetInput || !funcSwitchRun |=> !cpuRun;
  endproperty
  property p_out_off;
    selfHoldClear [*2] |-> physOutputs == 16'h0;
  endproperty
  property p_init_pulse;
    linkInitPulse |=> !linkInitPulse;
  endproperty
  property p_low_half;
    $rose(oneSecPulse) |-> loCnt >= HALF_SEC_CYCLES - 1;
  endproperty
  property p_card_gone;
    !cardInserted [*2] |-> !cardAccessEnable;
  endproperty
  a_rd_answer: assert property (p_rd_answer)
    else $error("read answer late");
  a_rd_block: assert property (p_rd_block)
    else $error("arready high with rvalid");
  a_wr_done: assert property (p_wr_done)
    else $error("bvalid kept after bready");
  a_override: assert property (p_override)
    else $error("run despite override");
  a_out_off: assert property (p_out_off)
    else $error("outputs on while off");
  a_init_pulse: assert property (p_init_pulse)
    else $error("init pulse too long");
  a_low_half: assert property (p_low_half)
    else $error("pulse low half short");
  a_card_gone: assert property (p_card_gone)
    else $error("card access without card");
endmodule : csf_flag_bank_props

// ---- dv/test_csf_flag_bank.sv ----
// Purpose: directed bench for the special flag bank
// Assumes: short half-second and link counts
// Notes: registers reached over AXI4-Lite tasks
`timescale 1ns/1ps
module test_csf_flag_bank;
  localparam int unsigned HALF = 5;
  logic clk = 0, rst = 1, s_axi_awvalid = 0, s_axi_wvalid = 0;
  logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic funcSwitchRun = 1, stopInput = 0, resetInput = 0, startRestore = 0;
  logic addCarry = 0, subBorrow = 0, progError = 0, linkError = 0;
  logic linkMaster = 1, linkRxOk = 0, clkReadDone = 0, clkReadFail = 0;
  logic cardInserted = 0, cardRecognised = 0, cardAccessing = 0;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [15:0] userOutputs = 16'h0, physOutputs;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, cpuRun, startBackup, oneSecPulse, selfHoldClear;
  logic linkSuspend, linkInitPulse, statusLamp, cardAccessEnable;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [32:0] rxCancel;
  int nMismatch = 0, numChecks = 0;
  // ==========================================
  // clock and design
  initial forever #5 clk = ~clk;
  csf_flag_bank #(.HALF_SEC_CYCLES(HALF), .LINK_TIMEOUT_CYCLES(20)) u_csf_flag_bank (.*);
  // ==========================================
  // shared tasks
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    numChecks++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", n, e, g);
      nMismatch++;
    end
  endtask : chk
  // write holds each valid until its own ready
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    forever begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid) begin
        rsp = s_axi_bresp;
        break;
      end
    end
    s_axi_bready <= 1'h0;
  endtask : wr
  task automatic rdr(input logic [7:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    forever begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid) begin
        rd = s_axi_rdata;
        break;
      end
    end
    s_axi_rready <= 1'h0;
  endtask : rdr
  // ==========================================
  // scenarios
  task automatic t_run;
    wr(csf_pkg::OFF_CTRL, 32'h1);
    cyc(3);
    chk("cpuRun", 32'h1, 32'(cpuRun));
    stopInput <= 1'h1;
    cyc(2);
    chk("cpuRun", 32'h0, 32'(cpuRun));
    stopInput <= 1'h0;
    wr(csf_pkg::OFF_CTRL, 32'h11);
    wr(csf_pkg::OFF_CTRL, 32'h29);
    cyc(3);
    chk("lamp", 32'h1, 32'(statusLamp));
    chk("suspend", 32'h1, 32'(linkSuspend));
    wr(csf_pkg::OFF_CANCEL_LO, 32'hffffffff);
    wr(csf_pkg::OFF_CANCEL_HI, 32'h1);
    cyc(3);
    chk("rxCancel", 32'h1, {31'h0, rxCancel[32]} & rxCancel[31:0]);
    wr(8'h40, 32'h1);
    chk("bresp", 32'(csf_pkg::RESP_SLVERR), 32'(rsp));
    $display("run test done");
  endtask : t_run
  task automatic t_out;
    userOutputs <= 16'ha5a5;
    wr(csf_pkg::OFF_CTRL, 32'h5);
    cyc(3);
    chk("physOff", 32'h0, 32'(physOutputs));
    wr(csf_pkg::OFF_CTRL, 32'h41);
    stopInput <= 1'h1;
    cyc(3);
    userOutputs <= 16'h0f0f;
    cyc(3);
    chk("physHeld", 32'ha5a5, 32'(physOutputs));
    stopInput <= 1'h0;
    cyc(3);
    rdr(csf_pkg::OFF_CTRL);
    chk("holdBit", 32'h0, rd & 32'h40);
    $display("output test done");
  endtask : t_out
  task automatic t_flags;
    addCarry <= 1'h1;
    progError <= 1'h1;
    linkError <= 1'h1;
    clkReadDone <= 1'h1;
    clkReadFail <= 1'h1;
    cyc(1);
    addCarry <= 1'h0;
    progError <= 1'h0;
    linkError <= 1'h0;
    clkReadDone <= 1'h0;
    rdr(csf_pkg::OFF_STATUS);
    chk("sticky", 32'h17, rd & 32'h17);
    wr(csf_pkg::OFF_STATUS, 32'h3);
    subBorrow <= 1'h1;
    clkReadDone <= 1'h1;
    clkReadFail <= 1'h0;
    cyc(1);
    subBorrow <= 1'h0;
    clkReadDone <= 1'h0;
    rdr(csf_pkg::OFF_STATUS);
    chk("borrow", 32'h5, rd & 32'h17);
    wr(csf_pkg::OFF_CTRL, 32'h3);
    rd = 32'h0;
    repeat (20) @(posedge clk) rd = rd + 32'(oneSecPulse);
    chk("pulseRst", 32'h0, rd);
    wr(csf_pkg::OFF_CTRL, 32'h1);
    cyc(3);
    rd = 32'h0;
    repeat (8 * HALF) @(posedge clk) rd = rd + 32'(oneSecPulse);
    chk("pulseDuty", 32'(4 * HALF), rd);
    $display("flag test done");
  endtask : t_flags
  task automatic t_clock;
    logic [31:0] d;
    wr(csf_pkg::OFF_STAGE_TIME, 32'h1168);
    wr(csf_pkg::OFF_TRIG, 32'h2);
    wr(csf_pkg::OFF_TRIG, 32'h0);
    rdr(csf_pkg::OFF_CLOCK_TIME);
    chk("time", 32'h1140, rd & 32'h1ffc0);
    wr(csf_pkg::OFF_TRIG, 32'h8);
    wr(csf_pkg::OFF_TRIG, 32'h0);
    rdr(csf_pkg::OFF_CLOCK_TIME);
    chk("adjust", 32'h1180, rd & 32'h1fffc);
    for (int i = 0; i < 2; i++) begin
      d = {12'h0, 8'h20 + 8'(i), 4'h3, 5'hf, 3'h2};
      wr(csf_pkg::OFF_STAGE_DATE, d);
      wr(csf_pkg::OFF_TRIG, (i == 0) ? 32'h1 : 32'h4);
      wr(csf_pkg::OFF_TRIG, 32'h0);
      rdr(csf_pkg::OFF_CLOCK_DATE);
      chk("date", d, rd);
    end
    wr(csf_pkg::OFF_STAGE_DATE, {12'h0, 8'h22, 4'hd, 5'hf, 3'h2});
    wr(csf_pkg::OFF_TRIG, 32'h1);
    rdr(csf_pkg::OFF_STATUS);
    chk("wrErr", 32'h8, rd & 32'h8);
    rdr(csf_pkg::OFF_CLOCK_DATE);
    chk("dateKept", d, rd);
    $display("clock test done");
  endtask : t_clock
  task automatic t_card;
    cardInserted <= 1'h1;
    cardRecognised <= 1'h1;
    cardAccessing <= 1'h1;
    rdr(csf_pkg::OFF_STATUS);
    chk("card", 32'h60, rd & 32'h60);
    wr(csf_pkg::OFF_CTRL, 32'h81);
    cyc(3);
    chk("unmount", 32'h0, 32'(cardAccessEnable));
    cardInserted <= 1'h0;
    wr(csf_pkg::OFF_CTRL, 32'h1);
    rdr(csf_pkg::OFF_STATUS);
    chk("mounted", 32'h0, rd & 32'h20);
    cardInserted <= 1'h1;
    cyc(3);
    chk("reinsert", 32'h1, 32'(cardAccessEnable));
    $display("card test done");
  endtask : t_card
  task automatic t_link;
    linkMaster <= 1'h0;
    cyc(25);
    rdr(csf_pkg::OFF_CTRL);
    chk("stop", 32'h10, rd & 32'h10);
    linkRxOk <= 1'h1;
    cyc(1);
    linkRxOk <= 1'h0;
    rdr(csf_pkg::OFF_CTRL);
    chk("rx", 32'h0, rd & 32'h10);
    $display("link test done");
  endtask : t_link
  task automatic t_restore;
    startRestore <= 1'h1;
    rst <= 1'h1;
    cyc(2);
    rst <= 1'h0;
    cyc(3);
    chk("restore", 32'h1, 32'(cpuRun));
    chk("backup", 32'h1, 32'(startBackup));
    $display("restore test done");
  endtask : t_restore
  // ==========================================
  // verdict, main sequence and watchdog
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", numChecks, nMismatch);
    if (nMismatch == 0 && numChecks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : print_verdict
  initial begin
    cyc(2);
    rst <= 1'h0;
    t_run();
    t_out();
    t_flags();
    t_clock();
    t_card();
    t_link();
    t_restore();
    print_verdict();
  end
  // whole run needs well under two thousand cycles
  initial begin
    cyc(20000);
    nMismatch++;
    print_verdict();
  end
endmodule : test_csf_flag_bank
bind csf_flag_bank csf_flag_bank_props #(.HALF_SEC_CYCLES(HALF_SEC_CYCLES)) u_csf_flag_bank_props (.*);

// ---- rtl/csf_flag_bank.sv ----
// Purpose: special control and status flag bank of the controller
// Assumes: all event inputs are synchronous pulses or levels on clk
// Notes: registers reached over AXI4-Lite, outputs all registered
//
// How it works
// - start flag set runs, clear stops
// - switch, stop and reset inputs override start
// - start flag survives power-down via backup
// - pulse reset flag holds one-second pulse low
// - one-second pulse: 500 ms high, 500 low
// - outputs-off flag forces all outputs inactive
// - carry or borrow sets carry flag
// - program execution error sets error flag
// - link error flag sets and stays set until written one to clear
// - link inhibit suspends master link traffic
// - init flag rise in run reinitialises master link
// - slave: 10 s silence sets stop flag
// - lamp flag drives status lamp
// - clock write result sets/clears write error
// - clock read result sets/clears read error
// - date trigger copies staged date to clock
// - time trigger copies staged time to clock
// - combined trigger copies date and time
// - seconds adjust zeroes seconds, rounds minutes
// - per-port cancel flags abort pending receives
// - hold flag keeps outputs in stop; auto-clears
// - card mounted only while recognised and usable
// - card busy high during card access while mounted
// - unmount stops access until card reinserted
//
// Local design decisions: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
module csf_flag_bank #(
  parameter int unsigned HALF_SEC_CYCLES = csf_pkg::HALF_SEC_CYC,
  parameter int unsigned LINK_TIMEOUT_CYCLES = csf_pkg::LINK_TO_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [csf_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [csf_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic funcSwitchRun,
  input wire logic stopInput,
  input wire logic resetInput,
  input wire logic startRestore,
  input wire logic addCarry,
  input wire logic subBorrow,
  input wire logic progError,
  input wire logic linkError,
  input wire logic linkMaster,
  input wire logic linkRxOk,
  input wire logic clkReadDone,
  input wire logic clkReadFail,
  input wire logic cardInserted,
  input wire logic cardRecognised,
  input wire logic cardAccessing,
  input wire logic [csf_pkg::OUT_W-1:0] userOutputs,
  output logic cpuRun,
  output logic startBackup,
  output logic oneSecPulse,
  output logic [csf_pkg::OUT_W-1:0] physOutputs,
  output logic selfHoldClear,
  output logic linkSuspend,
  output logic linkInitPulse,
  output logic statusLamp,
  output logic [csf_pkg::NUM_PORTS-1:0] rxCancel,
  output logic cardAccessEnable
);
  // ==========================================================
  // helper functions
  function automatic logic [31:0] mergeBytes(input logic [31:0] old,
      input logic [31:0] val, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = val[8*i +: 8];
      end
    end
    return r;
  endfunction : mergeBytes

  function automatic csf_pkg::csf_time_t incMin(input csf_pkg::csf_time_t t);
    csf_pkg::csf_time_t r;
    r = t;
    if (t.min == csf_pkg::MIN_MAX) begin
      r.min = '0;
      r.hour = (t.hour == csf_pkg::HOUR_MAX) ? '0 : t.hour + 5'h01;
    end else begin
      r.min = t.min + 6'h01;
    end
    return r;
  endfunction : incMin

  function automatic logic timeOk(input csf_pkg::csf_time_t t);
    return (t.sec <= csf_pkg::SEC_MAX) && (t.min <= csf_pkg::MIN_MAX) &&
           (t.hour <= csf_pkg::HOUR_MAX);
  endfunction : timeOk

  function automatic logic dateOk(input csf_pkg::csf_date_t d);
    return (d.month != '0) && (d.month <= csf_pkg::MONTH_MAX) &&
           (d.day != '0) && (d.day <= csf_pkg::DAY_MAX) &&
           (d.wday <= csf_pkg::WDAY_MAX);
  endfunction : dateOk

  // ==========================================================
  // state
  logic [csf_pkg::CTL_W-1:0] ctrl;
  logic [csf_pkg::TRG_W-1:0] trig, trigQ;
  logic [csf_pkg::NUM_PORTS-1:0] cancel;
  csf_pkg::csf_date_t stageDate, clockDate;
  csf_pkg::csf_time_t stageTime, clockTime;
  logic carryFlag, execErr, linkErr, clkWrErr, clkRdErr;
  logic cardMounted, cardBusy, unmountLatch, restoreDone;
  logic [31:0] halfCnt, secCnt, silentCnt;
  logic awHeld, wHeld, linkInitQ;
  logic [csf_pkg::ADDR_W-1:0] awAddrQ;
  logic [31:0] wDataQ;
  logic [3:0] wStrbQ;

  // ==========================================================
  // AXI4-Lite write path: address and data taken in either order
  wire awTake = s_axi_awvalid & s_axi_awready;
  wire wTake = s_axi_wvalid & s_axi_wready;
  wire doWrite = awHeld & wHeld & ~s_axi_bvalid;
  wire next_awHeld = doWrite ? 1'b0 : (awHeld | awTake);
  wire next_wHeld = doWrite ? 1'b0 : (wHeld | wTake);
  wire wrCtrl = doWrite && awAddrQ == csf_pkg::OFF_CTRL;
  wire wrStatus = doWrite && awAddrQ == csf_pkg::OFF_STATUS;
  wire wrTrig = doWrite && awAddrQ == csf_pkg::OFF_TRIG;
  wire wrCanLo = doWrite && awAddrQ == csf_pkg::OFF_CANCEL_LO;
  wire wrCanHi = doWrite && awAddrQ == csf_pkg::OFF_CANCEL_HI;
  wire wrSDate = doWrite && awAddrQ == csf_pkg::OFF_STAGE_DATE;
  wire wrSTime = doWrite && awAddrQ == csf_pkg::OFF_STAGE_TIME;
  wire wrHit = wrCtrl | wrStatus | wrTrig | wrCanLo | wrCanHi | wrSDate |
               wrSTime || awAddrQ == csf_pkg::OFF_CLOCK_DATE ||
               awAddrQ == csf_pkg::OFF_CLOCK_TIME;
  // clear mask only on lanes actually strobed
  wire [31:0] w1c = mergeBytes(32'h0, wDataQ, wStrbQ) &
                    {32{wrStatus}};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddrQ <= '0;
      wDataQ <= '0;
      wStrbQ <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= csf_pkg::RESP_OKAY;
    end else begin
      awHeld <= next_awHeld;
      wHeld <= next_wHeld;
      s_axi_awready <= ~next_awHeld;
      s_axi_wready <= ~next_wHeld;
      if (awTake) begin
        awAddrQ <= s_axi_awaddr;
      end
      if (wTake) begin
        wDataQ <= s_axi_wdata;
        wStrbQ <= s_axi_wstrb;
      end
      if (doWrite) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrHit ? csf_pkg::RESP_OKAY : csf_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // AXI4-Lite read path: one read under way, answer next cycle
  wire arTake = s_axi_arvalid & s_axi_arready;
  wire next_rvalid = arTake | (s_axi_rvalid & ~s_axi_rready);
  wire [31:0] statusWord = {23'h0, oneSecPulse, cpuRun, cardBusy,
                            cardMounted, clkRdErr, clkWrErr, linkErr,
                            execErr, carryFlag};
  logic [31:0] rdMux;
  logic rdHit;
  always_comb begin
    rdHit = 1'b1;
    unique case (s_axi_araddr)
      csf_pkg::OFF_CTRL: rdMux = 32'(ctrl);
      csf_pkg::OFF_STATUS: rdMux = statusWord;
      csf_pkg::OFF_TRIG: rdMux = 32'(trig);
      csf_pkg::OFF_CANCEL_LO: rdMux = cancel[31:0];
      csf_pkg::OFF_CANCEL_HI: rdMux = 32'(cancel[csf_pkg::NUM_PORTS-1]);
      csf_pkg::OFF_STAGE_DATE: rdMux = 32'(stageDate);
      csf_pkg::OFF_STAGE_TIME: rdMux = 32'(stageTime);
      csf_pkg::OFF_CLOCK_DATE: rdMux = 32'(clockDate);
      csf_pkg::OFF_CLOCK_TIME: rdMux = 32'(clockTime);
      default: begin
        rdMux = 32'h0;
        rdHit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= csf_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= ~next_rvalid;
      s_axi_rvalid <= next_rvalid;
      if (arTake) begin
        s_axi_rdata <= rdMux;
        s_axi_rresp <= rdHit ? csf_pkg::RESP_OKAY : csf_pkg::RESP_SLVERR;
      end
    end
  end

  // ==========================================================
  // run/stop and control register
  // inputs override start
  wire runReq = ctrl[csf_pkg::CTL_START] & funcSwitchRun & ~stopInput &
                ~resetInput;
  wire runRise = runReq & ~cpuRun;
  wire linkTimeout = ~linkMaster && ~linkRxOk &&
                     silentCnt >= LINK_TIMEOUT_CYCLES - 32'd1;
  wire [31:0] ctrlSw = mergeBytes(32'(ctrl), wDataQ, wStrbQ);
  logic [csf_pkg::CTL_W-1:0] next_ctrl;
  always_comb begin
    next_ctrl = wrCtrl ? ctrlSw[csf_pkg::CTL_W-1:0] : ctrl;
    if (!restoreDone) begin
      next_ctrl[csf_pkg::CTL_START] = startRestore;
    end
    if (runRise) begin
      next_ctrl[csf_pkg::CTL_HOLD] = 1'b0;
    end
    if (linkTimeout) begin
      next_ctrl[csf_pkg::CTL_LINK_INIT] = 1'b1;
    end else if (!linkMaster && linkRxOk) begin
      next_ctrl[csf_pkg::CTL_LINK_INIT] = 1'b0;
    end
  end

  // start value is caught after release, never under reset itself
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl <= csf_pkg::CTRL_RST;
      restoreDone <= 1'b0;
      cpuRun <= 1'b0;
      startBackup <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      restoreDone <= 1'b1;
      cpuRun <= runReq;
      startBackup <= next_ctrl[csf_pkg::CTL_START];
    end
  end

  // ==========================================================
  // software-written flag words
  wire [31:0] trigSw = mergeBytes(32'(trig), wDataQ, wStrbQ);
  wire [31:0] canLoSw = mergeBytes(cancel[31:0], wDataQ, wStrbQ);
  wire [31:0] canHiSw = mergeBytes(32'(cancel[csf_pkg::NUM_PORTS-1]),
                                   wDataQ, wStrbQ);
  wire [31:0] sDateSw = mergeBytes(32'(stageDate), wDataQ, wStrbQ);
  wire [31:0] sTimeSw = mergeBytes(32'(stageTime), wDataQ, wStrbQ);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      trig <= '0;
      trigQ <= '0;
      cancel <= '0;
      stageDate <= '0;
      stageTime <= '0;
    end else begin
      trig <= wrTrig ? trigSw[csf_pkg::TRG_W-1:0] : trig;
      trigQ <= trig;
      cancel[31:0] <= wrCanLo ? canLoSw : cancel[31:0];
      cancel[csf_pkg::NUM_PORTS-1] <= wrCanHi ? canHiSw[0] :
                                      cancel[csf_pkg::NUM_PORTS-1];
      stageDate <= wrSDate ? sDateSw[csf_pkg::DATE_W-1:0] : stageDate;
      stageTime <= wrSTime ? sTimeSw[csf_pkg::TIME_W-1:0] : stageTime;
    end
  end

  // ==========================================================
  // sticky event flags and clock read error; a set in the clearing cycle wins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      carryFlag <= 1'b0;
      execErr <= 1'b0;
      linkErr <= 1'b0;
      clkRdErr <= 1'b0;
    end else begin
      carryFlag <= addCarry | subBorrow |
                   (carryFlag & ~w1c[csf_pkg::ST_CARRY]);
      execErr <= progError | (execErr & ~w1c[csf_pkg::ST_EXEC_ERR]);
      linkErr <= linkError | (linkErr & ~w1c[csf_pkg::ST_LINK_ERR]);
      if (clkReadDone) begin
        clkRdErr <= clkReadFail;
      end
    end
  end

  // ==========================================================
  // internal calendar clock; day does not roll over at midnight
  // rising edge triggers
  wire [csf_pkg::TRG_W-1:0] trigRise = trig & ~trigQ;
  wire dateWr = trigRise[csf_pkg::TRG_DATE] | trigRise[csf_pkg::TRG_BOTH];
  wire timeWr = trigRise[csf_pkg::TRG_TIME] | trigRise[csf_pkg::TRG_BOTH];
  wire adjReq = trigRise[csf_pkg::TRG_ADJ];
  wire wrValid = (~dateWr | dateOk(stageDate)) &
                 (~timeWr | timeOk(stageTime));
  wire secTick = secCnt == 2 * HALF_SEC_CYCLES - 32'd1;
  csf_pkg::csf_time_t zeroSec, adjTime, tickTime, next_time;
  always_comb begin
    zeroSec = clockTime;
    zeroSec.sec = '0;
    adjTime = (clockTime.sec >= csf_pkg::SEC_ROUND) ? incMin(zeroSec) :
              zeroSec;
    tickTime = clockTime;
    tickTime.sec = clockTime.sec + 6'h01;
    if (clockTime.sec >= csf_pkg::SEC_MAX) begin
      tickTime = incMin(zeroSec);
    end
    // explicit write beats adjust, adjust beats the tick
    if (timeWr && wrValid) begin
      next_time = stageTime;
    end else if (adjReq) begin
      next_time = adjTime;
    end else if (secTick) begin
      next_time = tickTime;
    end else begin
      next_time = clockTime;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      clockTime <= '0;
      clockDate <= '0;
      clkWrErr <= 1'b0;
      secCnt <= '0;
    end else begin
      clockTime <= next_time;
      secCnt <= secTick ? 32'd0 : secCnt + 32'd1;
      if (dateWr && wrValid) begin
        clockDate <= stageDate;
      end
      if (dateWr | timeWr | adjReq) begin
        clkWrErr <= ~wrValid;
      end
    end
  end

  // ==========================================================
  // one-second pulse and link supervision
  wire halfEnd = halfCnt == HALF_SEC_CYCLES - 32'd1;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      halfCnt <= '0;
      oneSecPulse <= 1'b0;
      silentCnt <= '0;
      linkInitQ <= 1'b0;
      linkInitPulse <= 1'b0;
      linkSuspend <= 1'b0;
    end else begin
      if (ctrl[csf_pkg::CTL_PULSE_RST]) begin
        halfCnt <= '0;
        oneSecPulse <= 1'b0;
      end else begin
        halfCnt <= halfEnd ? 32'd0 : halfCnt + 32'd1;
        oneSecPulse <= oneSecPulse ^ halfEnd;
      end
      // counter saturates so the stop flag stays set while silent
      if (linkMaster || linkRxOk) begin
        silentCnt <= '0;
      end else if (!linkTimeout) begin
        silentCnt <= silentCnt + 32'd1;
      end
      linkInitQ <= ctrl[csf_pkg::CTL_LINK_INIT];
      linkInitPulse <= linkMaster & cpuRun &
                       ctrl[csf_pkg::CTL_LINK_INIT] & ~linkInitQ;
      linkSuspend <= linkMaster & ctrl[csf_pkg::CTL_LINK_INH];
    end
  end

  // ==========================================================
  // outputs, lamp, receive cancel and memory card
  wire cardUsable = cardInserted & cardRecognised & ~unmountLatch &
                    ~ctrl[csf_pkg::CTL_UNMOUNT];
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      physOutputs <= '0;
      selfHoldClear <= 1'b0;
      statusLamp <= 1'b0;
      rxCancel <= '0;
      unmountLatch <= 1'b0;
      cardMounted <= 1'b0;
      cardBusy <= 1'b0;
      cardAccessEnable <= 1'b0;
    end else begin
      if (ctrl[csf_pkg::CTL_OUT_OFF]) begin
        physOutputs <= '0;
      end else if (cpuRun) begin
        physOutputs <= userOutputs;
      end else if (!ctrl[csf_pkg::CTL_HOLD]) begin
        physOutputs <= '0;
      end
      selfHoldClear <= ctrl[csf_pkg::CTL_OUT_OFF];
      statusLamp <= ctrl[csf_pkg::CTL_LAMP];
      rxCancel <= cancel;
      if (!cardInserted) begin
        unmountLatch <= 1'b0;
      end else if (ctrl[csf_pkg::CTL_UNMOUNT]) begin
        unmountLatch <= 1'b1;
      end
      cardMounted <= cardUsable;
      cardAccessEnable <= cardUsable;
      cardBusy <= cardAccessing & cardUsable;
    end
  end
endmodule : csf_flag_bank

// ---- rtl/csf_pkg.sv ----
// Purpose: constants, offsets and carrier types for the special flag bank
// Assumes: 100 MHz scan clock, AXI4-Lite register access, 32-bit data
// Notes: every register takes one aligned word; unused bits read zero
package csf_pkg;
  // ==========================================================
  // bus and register map
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_TRIG = 8'h08;
  localparam logic [7:0] OFF_CANCEL_LO = 8'h0c;
  localparam logic [7:0] OFF_CANCEL_HI = 8'h10;
  localparam logic [7:0] OFF_STAGE_DATE = 8'h14;
  localparam logic [7:0] OFF_STAGE_TIME = 8'h18;
  localparam logic [7:0] OFF_CLOCK_DATE = 8'h1c;
  localparam logic [7:0] OFF_CLOCK_TIME = 8'h20;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================================
  // control register bit positions
  localparam int CTL_START = 0;
  localparam int CTL_PULSE_RST = 1;
  localparam int CTL_OUT_OFF = 2;
  localparam int CTL_LINK_INH = 3;
  localparam int CTL_LINK_INIT = 4;
  localparam int CTL_LAMP = 5;
  localparam int CTL_HOLD = 6;
  localparam int CTL_UNMOUNT = 7;
  localparam int CTL_W = 8;
  // status register bit positions (low three are write-one-to-clear)
  localparam int ST_CARRY = 0;
  localparam int ST_EXEC_ERR = 1;
  localparam int ST_LINK_ERR = 2;
  localparam int ST_CLK_WR_ERR = 3;
  localparam int ST_CLK_RD_ERR = 4;
  localparam int ST_CARD_MNT = 5;
  localparam int ST_CARD_BUSY = 6;
  localparam int ST_RUN = 7;
  localparam int ST_PULSE = 8;
  // trigger register bit positions
  localparam int TRG_DATE = 0;
  localparam int TRG_TIME = 1;
  localparam int TRG_BOTH = 2;
  localparam int TRG_ADJ = 3;
  localparam int TRG_W = 4;
  // ==========================================================
  // reset values, sizes and timing
  localparam logic [CTL_W-1:0] CTRL_RST = 8'h00;
  localparam int NUM_PORTS = 33;
  localparam int OUT_W = 16;
  localparam int CLK_HZ = 100_000_000;
  localparam int HALF_SEC_MS = 500;
  localparam int LINK_TO_S = 10;
  localparam int HALF_SEC_CYC = (CLK_HZ / 1000) * HALF_SEC_MS;
  localparam int LINK_TO_CYC = CLK_HZ * LINK_TO_S;
  // ==========================================================
  // calendar limits
  localparam logic [5:0] SEC_ROUND = 6'h1e;
  localparam logic [5:0] SEC_MAX = 6'h3b;
  localparam logic [5:0] MIN_MAX = 6'h3b;
  localparam logic [4:0] HOUR_MAX = 5'h17;
  localparam logic [3:0] MONTH_MAX = 4'hc;
  localparam logic [4:0] DAY_MAX = 5'h1f;
  localparam logic [2:0] WDAY_MAX = 3'h6;
  typedef struct packed {
    logic [4:0] hour;
    logic [5:0] min;
    logic [5:0] sec;
  } csf_time_t;
  typedef struct packed {
    logic [7:0] year;
    logic [3:0] month;
    logic [4:0] day;
    logic [2:0] wday;
  } csf_date_t;
  localparam int TIME_W = $bits(csf_time_t);
  localparam int DATE_W = $bits(csf_date_t);
endpackage : csf_pkg
